// ===== hdl/tlm_calc.sv
/*
 * Automatic threshold from teach peak and sensitivity.
 * Assumes peak in hundredths of a percent; purely combinational.
 */
`timescale 1ns/1ps
`include "tlm_regs.svh"
module tlm_calc
	import tlm_pkg::*;
(
	input wire tlm_pct_t peak,
	input wire tlm_set_t sens,
	output tlm_pct_t thr
);
	logic [23:0] prod;
	logic [23:0] quo;

	// Scale grows with sensitivity: 0.1 gives the lowest, just above the peak
	always_comb begin
		prod = {10'h000, peak} * {14'h0000, {1'b0, sens} + `TLM_CALC_OFS};
		quo = prod / `TLM_CALC_DIV;
		if (quo > {10'h000, `TLM_THR_CLAMP}) begin
			thr = `TLM_THR_CLAMP;
		end else begin
			thr = quo[13:0];
		end
	end
endmodule

// ===== hdl/tlm_chan.sv
/*
 * One switching channel: activation, hold time, latch and release.
 * Assumes a one-cycle tick every millisecond from the core.
 */
`timescale 1ns/1ps
module tlm_chan (
	input wire logic sys_clk,
	input wire logic rst_n,
	tlm_ch_if.chan ch
);
	logic active_q;
	logic [9:0] cnt_q;

	assign ch.active = active_q;

	// Hold counter loads hold+1 so the tick phase never shortens the hold
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= 1'b0;
			cnt_q <= 10'h000;
		end else if (!ch.run) begin
			active_q <= 1'b0;
			cnt_q <= 10'h000;
		end else if (!active_q) begin
			if (ch.en && ch.above) begin
				active_q <= 1'b1;
				cnt_q <= {1'b0, ch.hold} + 10'h001;
			end
		end else if (ch.hold != 9'h000) begin
			if (cnt_q != 10'h000) begin
				if (ch.tick) begin
					cnt_q <= cnt_q - 10'h001;
				end
			end else if (!ch.above) begin
				active_q <= 1'b0;
			end
		end // Hold of zero: stays set until the cycle ends
	end
endmodule

// ===== hdl/tlm_top.sv
/*
 * Four-level threshold monitor with teach, hold timing, output routing
 * and a classic Wishbone register slave.
 * Assumes meas_level is sampled on sys_clk; pin inputs are asynchronous.
 */
// Summary of operation
// - Each of four thresholds switches its own output when level exceeds it.
// - Teach lasts five seconds; infeed enable stays inactive meanwhile.
// - During teach the largest level is kept as the teach peak.
// - Teach completion: new thresholds, infeed active, cycle starts afresh.
// - Teach stopped early: no thresholds, no infeed, no switching.
// - Sensitivity spans 0.0 to 39.9, default 3.0; zero means manual.
// - Hold time spans 0 to 500 ms, default zero.
// - Sensitivity zero uses the manual threshold directly.
// - Sensitivity above zero derives threshold from teach peak; 0.1 lowest.
// - Computed threshold never exceeds 97 percent.
// - Thresholds recomputed each start; peak only changes through teach.
// - Teach leaves a manual threshold unchanged.
// - Automatic mode reports computed value, overwrites edits at next start.
// - Sensitivity zero with threshold zero disables that threshold.
// - An active output stays on at least the hold time.
// - Hold time zero latches the output until the cycle ends.
// - All switching outputs drop when the cycle stops.
// - Hardware gap and crash compare only if enabled and revision 04 up.
// - Hardware mode: gap on 4 or 5, crash on 6, limits at base, base+1.
// - Software mode: four thresholds on base to base+3 in order.
// - A disabled threshold does not move the others' outputs.
// - Outputs past the last have no destination; gap pin is not shared.
// - Base selection off kills software outputs, hardware ones keep working.
`timescale 1ns/1ps
`include "tlm_regs.svh"
module tlm_top
	import tlm_pkg::*;
#(
	parameter int MW = 12,
	parameter int NOUT = 8,
	parameter logic [7:0] LOGIC_REV = 8'h04,
	parameter int MS_CYC = `TLM_MS_NS / `TLM_CLK_NS,
	parameter int TEACH_MS = `TLM_TEACH_MS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [MW-1:0] meas_level,
	input wire logic job_run_pin,
	input wire logic teach_pin,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [NOUT-1:0] sw_out,
	output logic infeed_en
);
	localparam int NTH = 4;

	tlm_mode_t mode_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] sync3_q;
	logic job_s;
	logic teach_s;
	logic [16:0] tick_cnt_q;
	logic tick_q;
	logic [12:0] teach_cnt_q;
	logic start_q;
	logic pend_q;
	tlm_pct_t meas_pct;
	tlm_pct_t peak_run_q;
	tlm_pct_t peak_q;
	logic hw_cmp_q;
	logic sensor2_q;
	logic [3:0] base_q;
	logic hw_ok;
	tlm_set_t sens_q [NTH];
	tlm_set_t hold_q [NTH];
	tlm_pct_t thr_q [NTH];
	tlm_pct_t calc_w [NTH];
	logic [NTH-1:0] act_w;
	logic [NTH-1:0] en_w;
	logic [NTH-1:0] dest_ok;
	logic [4:0] pos_w [NTH];
	logic [NTH-1:0] hw_ch;
	logic [NTH-1:0] above_w;
	logic [NTH-1:0] thr_on;
	logic [NOUT-1:0] sw_d;
	logic [NOUT-1:0] sw_q;
	logic infeed_q;
	logic acc;
	logic [31:0] rdat_d;
	logic [31:0] rdat_q;
	logic ack_q;
	logic [MW+13:0] pct_prod;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: the pins come from opto-isolated inputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
		end else begin
			sync1_q <= {teach_pin, job_run_pin};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign job_s = sync2_q[0];
	assign teach_s = sync2_q[1];

	// Millisecond tick shared by teach timing and every hold counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= 17'h00000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 17'(MS_CYC - 1)) begin
			tick_cnt_q <= 17'h00000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 17'h00001;
			tick_q <= 1'b0;
		end
	end

	// Level in hundredths of a percent of full scale
	always_comb begin
		pct_prod = (MW+14)'(meas_level) * (MW+14)'(`TLM_PCT_SCALE);
		meas_pct = pct_prod[MW+13:MW];
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle state: teach on the teach pin, process on job pin or teach end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= TLM_IDLE;
			teach_cnt_q <= 13'h0000;
			pend_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			start_q <= pend_q;
			pend_q <= 1'b0;
			unique case (mode_q)
				TLM_IDLE: begin
					teach_cnt_q <= 13'h0000;
					if (teach_s && !sync3_q[1]) begin
						mode_q <= TLM_TEACH;
					end else if (job_s && !sync3_q[0]) begin
						mode_q <= TLM_RUN;
						start_q <= 1'b1;
					end
				end
				TLM_TEACH: begin
					if (!teach_s) begin
						mode_q <= TLM_IDLE;
					end else if (teach_cnt_q == 13'(TEACH_MS)) begin
						mode_q <= TLM_RUN;
						pend_q <= 1'b1; // Start after the new peak is stored
					end else if (tick_q) begin
						teach_cnt_q <= teach_cnt_q + 13'h0001;
					end
				end
				TLM_RUN: begin
					if (!job_s && !teach_s) begin
						mode_q <= TLM_IDLE;
					end
				end
				default: begin
					mode_q <= TLM_IDLE;
				end
			endcase
		end
	end

	// Peak tracking; the stored peak only moves at teach completion
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_run_q <= 14'h0000;
			peak_q <= 14'h0000;
		end else if (mode_q != TLM_TEACH) begin
			peak_run_q <= 14'h0000;
		end else if (teach_cnt_q == 13'(TEACH_MS)) begin
			peak_q <= peak_run_q;
		end else if (meas_pct > peak_run_q) begin
			peak_run_q <= meas_pct;
		end
	end

	// Infeed follows the process and is held off while teaching
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			infeed_q <= 1'b0;
		end else begin
			infeed_q <= (mode_q == TLM_RUN);
		end
	end
	assign infeed_en = infeed_q;

	////////////////////////////////////////////////////////////////////////
	// Threshold channels
	assign hw_ok = hw_cmp_q && (LOGIC_REV >= `TLM_HW_MIN_REV);

	genvar gi;
	generate
		for (gi = 0; gi < NTH; gi++) begin : g_th
			tlm_ch_if chi ();
			tlm_calc u_calc (
				.peak(peak_q),
				.sens(sens_q[gi]),
				.thr(calc_w[gi])
			);
			tlm_chan u_chan (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.ch(chi.chan)
			);
			// Channel held idle through the start cycles so stale thresholds never fire
			assign chi.run = (mode_q == TLM_RUN) && !start_q && !pend_q;
			assign chi.tick = tick_q;
			assign chi.hold = hold_q[gi];
			assign chi.above = meas_pct > thr_q[gi];
			assign chi.en = en_w[gi];
			assign act_w[gi] = chi.active;
			assign above_w[gi] = chi.above;
			assign thr_on[gi] = (sens_q[gi] != 9'h000) || (thr_q[gi] != 14'h0000);
			assign en_w[gi] = thr_on[gi] && dest_ok[gi];
		end
	endgenerate

	// Output positions; fixed regardless of which thresholds are off
	always_comb begin
		for (int k = 0; k < NTH; k++) begin
			hw_ch[k] = hw_ok && (k == 0 || k == NTH - 1);
			if (!hw_ok) begin
				pos_w[k] = {1'b0, base_q} + 5'(k) - 5'h01;
			end else if (k == 0) begin
				pos_w[k] = sensor2_q ? `TLM_GAP2_PIN : `TLM_GAP1_PIN;
			end else if (k == NTH - 1) begin
				pos_w[k] = `TLM_CRASH_PIN;
			end else begin
				pos_w[k] = {1'b0, base_q} + 5'(k) - 5'h02;
			end
			if (hw_ch[k]) begin
				dest_ok[k] = 1'b1;
			end else begin
				dest_ok[k] = (base_q != 4'h0) && (pos_w[k] < 5'(NOUT));
				if (hw_ok && (pos_w[k] == pos_w[0] || pos_w[k] == `TLM_CRASH_PIN)) begin
					dest_ok[k] = 1'b0;
				end
			end
		end
	end

	// Merge channel states onto the registered output pins
	always_comb begin
		sw_d = '0;
		for (int k = 0; k < NTH; k++) begin
			if (dest_ok[k] && act_w[k]) begin
				sw_d[pos_w[k][2:0]] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_q <= '0;
		end else begin
			sw_q <= sw_d;
		end
	end
	assign sw_out = sw_q;

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack for every address
	assign acc = wb_cyc_i && wb_stb_i && !ack_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= acc;
			rdat_q <= acc ? rdat_d : 32'h00000000;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Control register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hw_cmp_q <= 1'b0;
			sensor2_q <= 1'b0;
			base_q <= 4'h0;
		end else if (acc && wb_we_i && wb_adr_i == `TLM_ADR_CTRL && wb_sel_i[0]) begin
			hw_cmp_q <= wb_dat_i[`TLM_CTRL_HWCMP];
			sensor2_q <= wb_dat_i[`TLM_CTRL_SENSOR2];
			base_q <= wb_dat_i[`TLM_CTRL_BASE_LSB+:4];
		end
	end

	// Per-threshold settings; out-of-range writes saturate
	generate
		for (gi = 0; gi < NTH; gi++) begin : g_set
			logic wr_s;
			logic wr_t;
			assign wr_s = acc && wb_we_i && wb_adr_i == `TLM_ADR_SENS + 8'(4 * gi);
			assign wr_t = acc && wb_we_i && wb_adr_i == `TLM_ADR_THR + 8'(4 * gi);
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sens_q[gi] <= `TLM_SENS_RST;
					hold_q[gi] <= `TLM_HOLD_RST;
				end else if (wr_s) begin
					if (wb_sel_i[0]) begin
						sens_q[gi] <= (wb_dat_i[8:0] > `TLM_SENS_MAX) ?
							`TLM_SENS_MAX : wb_dat_i[8:0];
					end
					if (wb_sel_i[2]) begin
						hold_q[gi] <= (wb_dat_i[24:16] > `TLM_HOLD_MAX) ?
							`TLM_HOLD_MAX : wb_dat_i[24:16];
					end
				end
			end
			// Manual value is kept unless automatic mode reloads at start
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					thr_q[gi] <= `TLM_THR_RST;
				end else if (start_q && sens_q[gi] != 9'h000) begin
					thr_q[gi] <= calc_w[gi];
				end else if (wr_t && wb_sel_i[0] && wb_sel_i[1]) begin
					thr_q[gi] <= (wb_dat_i[13:0] > `TLM_THR_MAX) ?
						`TLM_THR_MAX : wb_dat_i[13:0];
				end
			end
		end
	endgenerate

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rdat_d = 32'h00000000;
		if (wb_adr_i == `TLM_ADR_CTRL) begin
			rdat_d[`TLM_CTRL_HWCMP] = hw_cmp_q;
			rdat_d[`TLM_CTRL_SENSOR2] = sensor2_q;
			rdat_d[`TLM_CTRL_BASE_LSB+:4] = base_q;
		end else if (wb_adr_i == `TLM_ADR_STAT) begin
			rdat_d[1:0] = mode_q;
			rdat_d[2] = infeed_q;
			rdat_d[3] = hw_ok;
			rdat_d[7:4] = act_w;
			rdat_d[11:8] = en_w;
			rdat_d[15:12] = above_w;
		end else if (wb_adr_i == `TLM_ADR_PEAK) begin
			rdat_d[13:0] = peak_q;
		end else begin
			for (int k = 0; k < NTH; k++) begin
				if (wb_adr_i == `TLM_ADR_SENS + 8'(4 * k)) begin
					rdat_d[8:0] = sens_q[k];
					rdat_d[24:16] = hold_q[k];
				end
				if (wb_adr_i == `TLM_ADR_THR + 8'(4 * k)) begin
					rdat_d[13:0] = thr_q[k];
				end
			end
		end
	end
endmodule

// ===== include/tlm_ch_if.sv
/*
 * Carrier between the monitor core and one threshold channel.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
interface tlm_ch_if;
	logic run;
	logic tick;
	logic en;
	logic above;
	logic [8:0] hold;
	logic active;
	modport ctl (output run, output tick, output en, output above, output hold, input active);
	modport chan (input run, input tick, input en, input above, input hold, output active);
endinterface

// ===== include/tlm_pkg.sv
/*
 * Types of the threshold level monitor.
 * Assumes tlm_regs.svh supplies the numeric constants.
 */
package tlm_pkg;
	typedef enum logic [1:0] {
		TLM_IDLE = 2'b00,
		TLM_TEACH = 2'b01,
		TLM_RUN = 2'b10
	} tlm_mode_t;
	typedef logic [13:0] tlm_pct_t;
	typedef logic [8:0] tlm_set_t;
endpackage

// ===== include/tlm_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of
 * the threshold level monitor. Assumes a 100 MHz system clock.
 */
`ifndef TLM_REGS_SVH
`define TLM_REGS_SVH

// Word offsets on the register bus
`define TLM_ADR_CTRL 8'h00
`define TLM_ADR_STAT 8'h04
`define TLM_ADR_PEAK 8'h08
`define TLM_ADR_SENS 8'h10
`define TLM_ADR_THR 8'h20

// Control fields
`define TLM_CTRL_HWCMP 0
`define TLM_CTRL_SENSOR2 1
`define TLM_CTRL_BASE_LSB 4

// Sensitivity register: sensitivity in tenths, hold time in ms
`define TLM_SENS_LSB 0
`define TLM_HOLD_LSB 16
`define TLM_SENS_RST 9'h01e
`define TLM_SENS_MAX 9'h18f
`define TLM_HOLD_RST 9'h000
`define TLM_HOLD_MAX 9'h1f4

// Thresholds in hundredths of a percent of full scale
`define TLM_THR_RST 14'h0032
`define TLM_THR_MAX 14'h2710
`define TLM_THR_CLAMP 14'h25e4
`define TLM_PCT_SCALE 14'h2710
`define TLM_CALC_OFS 10'h00a
`define TLM_CALC_DIV 24'h00000a

// Fixed hardware compare pins (zero based) and least logic revision
`define TLM_GAP1_PIN 5'h03
`define TLM_GAP2_PIN 5'h04
`define TLM_CRASH_PIN 5'h05
`define TLM_HW_MIN_REV 8'h04

// Timing
`define TLM_CLK_NS 10
`define TLM_MS_NS 1000000
`define TLM_TEACH_MS 5000

`endif

// ===== test/tlm_cnc_model.sv
/*
 * Machine control side: drives job and teach pins; the outputs are wired in but never read.
 * Assumes the bench calls drive() from its main sequence.
 */
`timescale 1ns/1ps
module tlm_cnc_model (
	input wire logic sys_clk,
	input wire logic [7:0] sw_out,
	input wire logic infeed_en,
	output logic job_run_pin,
	output logic teach_pin
);
	// Pins idle low from time zero
	initial begin
		job_run_pin = 1'b0;
		teach_pin = 1'b0;
	end
	// Pins change just after an edge, as an output card would
	task automatic drive(input bit j, input bit t);
		@(posedge sys_clk);
		job_run_pin <= j;
		teach_pin <= t;
	endtask
endmodule

// ===== test/tlm_tb.sv
/*
 * Self-checking bench for the threshold monitor.
 * Assumes 1 ms shortened to 10 cycles and teach to 5 ms.
 */
`timescale 1ns/1ps
`include "tlm_regs.svh"
module testbench;
	typedef struct {bit pin; string what; logic [31:0] exp;} tlm_note_t;
	tlm_note_t notes[$];
	tlm_note_t nt;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic probe = 1'b0;
	logic [11:0] meas = 12'h0;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] got;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic job, teach, wb_ack_o, infeed_en;
	logic [31:0] wb_dat_o;
	logic [7:0] sw_out;
	logic [31:0] thr_v[4] = '{32'h3e8, 32'hbb8, 32'h0, 32'hfa0};
	logic [7:0] ctrl_v[6] = '{8'h10, 8'h60, 8'h01, 8'h03, 8'h21, 8'h41};
	logic [7:0] exp_v[6] = '{8'h0b, 8'h60, 8'h28, 8'h30, 8'h2a, 8'h28};
	int fails = 0;
	int n_compared = 0;
	tlm_top #(.MS_CYC(10), .TEACH_MS(5)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.meas_level(meas), .job_run_pin(job), .teach_pin(teach), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sw_out(sw_out), .infeed_en(infeed_en));
	tlm_cnc_model cnc (.sys_clk(sys_clk), .sw_out(sw_out), .infeed_en(infeed_en),
		.job_run_pin(job), .teach_pin(teach));
	////////////////////////////////////////////////////////////////////////
	initial forever #5 sys_clk = ~sys_clk;
	// Compare at the falling edge, where registered outputs have settled
	always @(negedge sys_clk) begin
		if ((wb_ack_o === 1'b1 && !we) || probe) begin
			nt = notes.pop_front();
			got = nt.pin ? {23'h0, infeed_en, sw_out} : wb_dat_o;
			n_compared++;
			if (got !== nt.exp) begin
				fails++;
				$display("MISMATCH %s expected %h seen %h", nt.what, nt.exp, got);
			end
		end
	end
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One classic cycle; waits on ack, the watchdog bounds the wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
		notes.push_back('{1'b0, w, e});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic chk(input logic [31:0] e, input string w);
		notes.push_back('{1'b1, w, e});
		@(posedge sys_clk) probe <= 1'b1;
		@(posedge sys_clk) probe <= 1'b0;
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Run needs about 530 cycles; a hang ends well beyond that
	initial begin
		cycles(20000);
		fails++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h7543));
		cycles(20);
		rst_n <= 1'b1;
		rd(`TLM_ADR_SENS, 32'h1e, "sens0");
		rd(`TLM_ADR_THR, 32'h32, "thr0");
		xfer(1'b1, 8'h40, 32'h5a);
		rd(8'h40, 32'h0, "unmapped");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `TLM_ADR_SENS + 8'(4 * i), 32'h0);
			xfer(1'b1, `TLM_ADR_THR + 8'(4 * i), thr_v[i]);
		end
		// Route table: software, high base, hardware, sensor 2, mixed, limit on gap pin
		for (int i = 0; i < 6; i++) begin
			xfer(1'b1, `TLM_ADR_CTRL, {24'h0, ctrl_v[i]});
			cnc.drive(1'b1, 1'b0);
			cycles(8);
			meas <= 12'h800 + 12'($urandom % 1000);
			cycles(6);
			chk({23'h0, 1'b1, exp_v[i]}, "route");
			meas <= 12'h0;
			cycles(4);
			chk({23'h0, 1'b1, exp_v[i]}, "latch");
			cnc.drive(1'b0, 1'b0);
			cycles(8);
			chk(32'h0, "stop");
		end
		$display("test routing done");
		xfer(1'b1, `TLM_ADR_CTRL, 32'h10);
		xfer(1'b1, `TLM_ADR_SENS, 32'h30000);
		cnc.drive(1'b1, 1'b0);
		cycles(8);
		meas <= 12'h800;
		cycles(4);
		meas <= 12'h0;
		cycles(20);
		chk(32'h10b, "hold");
		cycles(30);
		chk(32'h10a, "expired");
		meas <= 12'h800;
		cycles(4);
		chk(32'h10b, "rearm");
		cnc.drive(1'b0, 1'b0);
		cycles(8);
		$display("test hold done");
		// Teach at 25 percent; threshold 0 sensitivity 1.0 doubles the peak
		xfer(1'b1, `TLM_ADR_SENS, 32'h3000a);
		meas <= 12'h400;
		cnc.drive(1'b0, 1'b1);
		cycles(20);
		cnc.drive(1'b0, 1'b0);
		cycles(8);
		rd(`TLM_ADR_PEAK, 32'h0, "early peak");
		chk(32'h0, "early");
		cnc.drive(1'b0, 1'b1);
		cycles(20);
		chk(32'h0, "teaching");
		cycles(60);
		chk(32'h100, "taught");
		rd(`TLM_ADR_PEAK, 32'h9c4, "peak");
		rd(`TLM_ADR_THR, 32'h1388, "auto thr");
		rd(`TLM_ADR_THR + 8'hc, 32'hfa0, "manual thr");
		cnc.drive(1'b0, 1'b0);
		cycles(8);
		xfer(1'b1, `TLM_ADR_SENS, 32'h3018f);
		cnc.drive(1'b1, 1'b0);
		cycles(8);
		rd(`TLM_ADR_THR, {18'h0, `TLM_THR_CLAMP}, "clamp");
		cnc.drive(1'b0, 1'b0);
		cycles(8);
		$display("test teach done");
		conclude();
	end
endmodule

// ===== test/tlm_top_sva.sv
/*
 * Port-level checker for the threshold monitor top.
 * Assumes one clock domain and pins driven off the clock edge.
 */
`timescale 1ns/1ps
module tlm_top_sva #(
	parameter int MW = 12,
	parameter int NOUT = 8,
	parameter int MS_CYC = 100000,
	parameter int TEACH_MS = 5000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [MW-1:0] meas_level,
	input wire logic job_run_pin,
	input wire logic teach_pin,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [NOUT-1:0] sw_out,
	input wire logic infeed_en
);
	localparam int TMAX = TEACH_MS * MS_CYC;
	// Last ms of teach is left out: the tick phase makes its end uncertain
	localparam int TLIM = (TEACH_MS - 1) * MS_CYC;
	logic pin_any_q;
	int tcnt_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// Any pin high one cycle ago
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			pin_any_q <= 1'b0;
		else
			pin_any_q <= job_run_pin || teach_pin;
	end
	// Teach age; a job pin disarms it, since a running cycle owns infeed
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			tcnt_q <= 0;
		else if (job_run_pin)
			tcnt_q <= TMAX;
		else if (!teach_pin)
			tcnt_q <= 0;
		else if (tcnt_q < TMAX)
			tcnt_q <= tcnt_q + 1;
	end
	////////////////////////////////////////////////////////////////////////
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	stop_clear_a: assert property (
		(!job_run_pin && !teach_pin) [*8] |-> sw_out == '0 && !infeed_en)
		else $error("outputs still active after stop");
	teach_hold_a: assert property (
		teach_pin && !job_run_pin && tcnt_q < TLIM |-> !infeed_en)
		else $error("infeed active during teach");
	infeed_cause_a: assert property ($rose(infeed_en) |-> pin_any_q)
		else $error("infeed rose with no pin active");
	job_start_a: assert property (
		job_run_pin && !teach_pin && !pin_any_q |-> ##[2:8] infeed_en)
		else $error("infeed late after job start");
endmodule
bind tlm_top tlm_top_sva #(.MW(MW), .NOUT(NOUT), .MS_CYC(MS_CYC), .TEACH_MS(TEACH_MS)) u_sva (
	.sys_clk(sys_clk), .rst_n(rst_n), .meas_level(meas_level), .job_run_pin(job_run_pin),
	.teach_pin(teach_pin), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .sw_out(sw_out), .infeed_en(infeed_en));
